//--- logic/epiu_defines.svh
// Constants of the external pin interrupt unit
// Function
// - Pin activity raises enabled requests even when the pin drives out.
// - Enabled low-level line requests continuously while its pin is low.
// - Edges on lines 7..4 need the I/O clock; level wake works asleep.
// - Power-down wake needs the low level on two watchdog clock samples.
// - Level gone before start-up end still wakes, but gives no request.
// - Lines 3..0: 00 low, 01 reserved, 10 falling, 11 rising edge.
// - Lines 3..0 catch edges without the I/O clock; short pulses may drop.
// - A line requests only when global enable and its mask bit are set.
// - Lines 7..4: 00 low, 01 any change, 10 falling, 11 rising edge.
// - Lines 7..4 detect edges from successive clocked samples.
// - Edge or change pulses longer than one clock give a request.
// - A detected edge or change sets the line flag.
// - Flag clears on entry to its routine or on a written one.
// - A line in level mode keeps its flag cleared.
// - Sleep with lines 3..0 masked disables their input buffers.
// - All sense fields reset to zero, low-level sensing.
// - A written enable bit arms the line if global enable is set.
// - Flag (low level in level mode), enable and global enable together direct the CPU vector.
`ifndef EPIU_DEFINES_SVH
`define EPIU_DEFINES_SVH
`define EPIU_IDX_FLAGS     8'h58
`define EPIU_IDX_MASK      8'h59
`define EPIU_IDX_SENSE_HI  8'h5A
`define EPIU_IDX_SENSE_LO  8'h6A
`define EPIU_ADDR_FLAGS    {2'h0, `EPIU_IDX_FLAGS, 2'h0}
`define EPIU_ADDR_MASK     {2'h0, `EPIU_IDX_MASK, 2'h0}
`define EPIU_ADDR_SENSE_HI {2'h0, `EPIU_IDX_SENSE_HI, 2'h0}
`define EPIU_ADDR_SENSE_LO {2'h0, `EPIU_IDX_SENSE_LO, 2'h0}
`define EPIU_RST_REG       8'h00
`define EPIU_CLK_PERIOD_NS 25
`define EPIU_MIN_PULSE_NS  50
`define EPIU_MIN_PULSE_CYC ((`EPIU_MIN_PULSE_NS+`EPIU_CLK_PERIOD_NS-1)/`EPIU_CLK_PERIOD_NS)
`define EPIU_RESP_OKAY     2'h0
`define EPIU_RESP_SLVERR   2'h2
`endif

//--- logic/epiu_pkg.sv
// Types of the external pin interrupt unit
package epiu_pkg;
   typedef enum logic [1:0]
   {
      SENSE_LOW  = 2'b00,
      SENSE_ANY  = 2'b01,
      SENSE_FALL = 2'b10,
      SENSE_RISE = 2'b11
   } epiu_sense_type;
   typedef enum logic [1:0]
   {
      WAKE_IDLE = 2'b00,
      WAKE_ONE  = 2'b01,
      WAKE_UP   = 2'b10
   } epiu_wake_type;
endpackage

//--- logic/epiu_line_if.sv
// Interface between the controller and one interrupt line
`timescale 1ns/1ps
`default_nettype none
interface epiu_line_if;
   import epiu_pkg::*;
   epiu_sense_type sense;
   logic           sample_en;
   logic           w1c;
   logic           ack;
   logic           flag;
   logic           level_low;
   modport ctrl (output sense, sample_en, w1c, ack,
                 input flag, level_low);
   modport line (input sense, sample_en, w1c, ack,
                 output flag, level_low);
endinterface
`default_nettype wire

//--- logic/epiu_line.sv
// One interrupt line: synchroniser, edge detector and flag
`timescale 1ns/1ps
`default_nettype none
module epiu_line
   import epiu_pkg::*;
#(
   parameter bit ASYNC_STYLE = 1'b0
)
(
   // Clock and reset
   input  wire logic  aclk,
   input  wire logic  aresetn,
   // Pin and controller side
   input  wire logic  pin,
   epiu_line_if.line  lif
);
   logic sync_a;
   logic sync_b;
   logic prev;
   logic rise;
   logic fall;
   logic hit;

   // Two-stage synchroniser and sample history
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
         prev   <= 1'b1;
      end
      else
      begin
         sync_a <= pin;
         sync_b <= sync_a;
         if (lif.sample_en)
            prev <= sync_b;
      end
   end

   // Edge decode from successive samples
   assign rise = lif.sample_en & sync_b & ~prev;
   assign fall = lif.sample_en & ~sync_b & prev;
   assign hit  = (lif.sense == SENSE_FALL) ? fall :
                 (lif.sense == SENSE_RISE) ? rise :
                 (lif.sense == SENSE_ANY && !ASYNC_STYLE) ?
                 (rise | fall) : 1'b0;
   assign lif.level_low = ~sync_b;

   // Sticky flag, set wins over clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         lif.flag <= 1'b0;
      else if (lif.sense == SENSE_LOW)
         lif.flag <= 1'b0;
      else if (hit)
         lif.flag <= 1'b1;
      else if (lif.w1c || lif.ack)
         lif.flag <= 1'b0;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_FLAG_SET: assert property (hit |=> lif.flag)
      else $error("edge did not set flag");
   AST_FLAG_CLR: assert property
      ((lif.w1c || lif.ack) && !hit |=> !lif.flag)
      else $error("flag not cleared");
   AST_LEVEL_CLR: assert property
      (lif.sense == SENSE_LOW |=> !lif.flag)
      else $error("flag set in level mode");
   AST_RESERVED: assert property
      (ASYNC_STYLE && lif.sense == SENSE_ANY && !lif.flag
       |=> !lif.flag)
      else $error("reserved mode set flag");
   AST_PULSE: assert property
      ((lif.sense == SENSE_RISE && lif.sample_en && !pin &&
        !lif.w1c && !lif.ack) ##1
       (lif.sense == SENSE_RISE && lif.sample_en && pin &&
        !lif.w1c && !lif.ack) [*5] |-> lif.flag)
      else $error("long pulse gave no flag");
   COV_FLAG: cover property (hit ##1 lif.flag ##[1:20] lif.w1c);
endmodule
`default_nettype wire

//--- logic/epiu_top.sv
// External pin interrupt unit with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "epiu_defines.svh"
module epiu_top
   import epiu_pkg::*;
#(
   parameter int NLINES = 8
)
(
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // AXI4-Lite write channels
   input  wire logic [11:0]  awaddr,
   input  wire logic [2:0]   awprot,
   input  wire logic         awvalid,
   output logic              awready,
   input  wire logic [31:0]  wdata,
   input  wire logic [3:0]   wstrb,
   input  wire logic         wvalid,
   output logic              wready,
   output logic [1:0]        bresp,
   output logic              bvalid,
   input  wire logic         bready,
   // AXI4-Lite read channels
   input  wire logic [11:0]  araddr,
   input  wire logic [2:0]   arprot,
   input  wire logic         arvalid,
   output logic              arready,
   output logic [31:0]       rdata,
   output logic [1:0]        rresp,
   output logic              rvalid,
   input  wire logic         rready,
   // Pins and watchdog oscillator
   input  wire logic [7:0]   ext_irq_pins,
   input  wire logic         wdt_osc_clk,
   // CPU and sleep controller
   input  wire logic         global_irq_enable,
   input  wire logic         irq_ack,
   input  wire logic [2:0]   irq_ack_line,
   input  wire logic         io_clk_running,
   input  wire logic         sleep_active,
   input  wire logic         power_down,
   // Requests and wake
   output logic [7:0]        irq_req,
   output logic              irq_pending,
   output logic [2:0]        irq_vector,
   output logic              wake_req,
   output logic [3:0]        input_buf_disable
);
   // ************************************************
   // Register slave
   // ************************************************
   logic          aw_held;
   logic          w_held;
   logic [11:0]   aw_addr_q;
   logic [7:0]    w_data_q;
   logic          w_strb_q;
   logic          next_aw_held;
   logic          next_w_held;
   logic          aw_hs;
   logic          w_hs;
   logic          ar_hs;
   logic          r_hs;
   logic          do_write;
   logic          wr_hit;
   logic          rd_hit;
   logic [7:0]    rd_val;
   logic [7:0]    sense_lo;
   logic [7:0]    sense_hi;
   logic [7:0]    line_mask;
   logic [7:0]    flag_clr;
   logic [7:0]    flags;
   logic [7:0]    lows;
   logic [7:0]    lvl_mode;
   logic [15:0]   sense_all;

   // Handshakes and write decode
   assign aw_hs    = awvalid & awready;
   assign w_hs     = wvalid & wready;
   assign ar_hs    = arvalid & arready;
   assign r_hs     = rvalid & rready;
   assign do_write = aw_held & w_held & ~bvalid;
   assign next_aw_held = aw_hs | (aw_held & ~do_write);
   assign next_w_held  = w_hs | (w_held & ~do_write);
   assign wr_hit = (aw_addr_q == `EPIU_ADDR_FLAGS) |
                   (aw_addr_q == `EPIU_ADDR_MASK) |
                   (aw_addr_q == `EPIU_ADDR_SENSE_HI) |
                   (aw_addr_q == `EPIU_ADDR_SENSE_LO);
   assign flag_clr = (do_write && w_strb_q &&
                      aw_addr_q == `EPIU_ADDR_FLAGS) ?
                     w_data_q : 8'h00;

   // Read decode
   assign rd_hit = (araddr == `EPIU_ADDR_FLAGS) |
                   (araddr == `EPIU_ADDR_MASK) |
                   (araddr == `EPIU_ADDR_SENSE_HI) |
                   (araddr == `EPIU_ADDR_SENSE_LO);
   assign rd_val = (araddr == `EPIU_ADDR_FLAGS)    ? flags :
                   (araddr == `EPIU_ADDR_MASK)     ? line_mask :
                   (araddr == `EPIU_ADDR_SENSE_HI) ? sense_hi :
                   (araddr == `EPIU_ADDR_SENSE_LO) ? sense_lo :
                   8'h00;

   // Write address and data capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         aw_addr_q <= 12'h000;
         w_data_q  <= 8'h00;
         w_strb_q  <= 1'b0;
      end
      else
      begin
         aw_held <= next_aw_held;
         w_held  <= next_w_held;
         awready <= ~next_aw_held;
         wready  <= ~next_w_held;
         if (aw_hs)
            aw_addr_q <= awaddr;
         if (w_hs)
         begin
            w_data_q <= wdata[7:0];
            w_strb_q <= wstrb[0];
         end
      end
   end

   // Write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp  <= `EPIU_RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid <= 1'b1;
         bresp  <= wr_hit ? `EPIU_RESP_OKAY : `EPIU_RESP_SLVERR;
      end
      else if (bvalid && bready)
         bvalid <= 1'b0;
   end

   // Control registers, sense fields reset to low level
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sense_lo  <= `EPIU_RST_REG;
         sense_hi  <= `EPIU_RST_REG;
         line_mask <= `EPIU_RST_REG;
      end
      else if (do_write && w_strb_q)
      begin
         if (aw_addr_q == `EPIU_ADDR_SENSE_LO)
            sense_lo <= w_data_q;
         if (aw_addr_q == `EPIU_ADDR_SENSE_HI)
            sense_hi <= w_data_q;
         if (aw_addr_q == `EPIU_ADDR_MASK)
            line_mask <= w_data_q;
      end
   end

   // Read channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `EPIU_RESP_OKAY;
      end
      else if (ar_hs)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= {24'h00_0000, rd_val};
         rresp   <= rd_hit ? `EPIU_RESP_OKAY : `EPIU_RESP_SLVERR;
      end
      else if (r_hs || !rvalid)
      begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
      end
   end

   // ************************************************
   // Interrupt lines
   // ************************************************
   logic [7:0] pin_gated;

   // Masked low lines lose their input buffer in sleep
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         input_buf_disable <= 4'h0;
      else
         input_buf_disable <= {4{sleep_active}} &
                              ~line_mask[3:0];
   end

   // Pins are read whatever their direction
   assign pin_gated = {ext_irq_pins[7:4],
                       ext_irq_pins[3:0] &
                       ~input_buf_disable};
   assign sense_all = {sense_hi, sense_lo};

   epiu_line_if lif [NLINES] ();

   genvar gi;
   generate
      for (gi = 0; gi < NLINES; gi++)
      begin : g_line
         assign lif[gi].sense =
            epiu_sense_type'(sense_all[2*gi +: 2]);
         assign lif[gi].sample_en =
            (gi < 4) ? 1'b1 : io_clk_running;
         assign lif[gi].w1c = flag_clr[gi];
         assign lif[gi].ack = irq_ack &
            (irq_ack_line == 3'(gi));
         assign flags[gi]    = lif[gi].flag;
         assign lows[gi]     = lif[gi].level_low;
         assign lvl_mode[gi] = (lif[gi].sense == SENSE_LOW);
         epiu_line #(
            .ASYNC_STYLE ((gi < 4) ? 1'b1 : 1'b0)
         ) u_line (
            .aclk    (aclk),
            .aresetn (aresetn),
            .pin     (pin_gated[gi]),
            .lif     (lif[gi])
         );
      end
   endgenerate

   // ************************************************
   // Request and priority
   // ************************************************
   logic [7:0] next_irq_req;
   logic [2:0] next_vector;

   // Flag or live level, gated by mask and global enable
   assign next_irq_req = line_mask & {8{global_irq_enable}} &
                         ((lvl_mode & lows) |
                          (~lvl_mode & flags));

   // Lowest index wins
   always_comb
   begin
      next_vector = 3'h0;
      for (int k = NLINES - 1; k >= 0; k--)
         if (next_irq_req[k])
            next_vector = 3'(k);
   end

   // Registered requests toward the CPU
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_req     <= 8'h00;
         irq_pending <= 1'b0;
         irq_vector  <= 3'h0;
      end
      else
      begin
         irq_req     <= next_irq_req;
         irq_pending <= |next_irq_req;
         irq_vector  <= next_vector;
      end
   end

   // ************************************************
   // Power-down wake from level
   // ************************************************
   logic          wdt_a;
   logic          wdt_b;
   logic          wdt_prev;
   logic          wdt_tick;
   logic          lvl_wake;
   epiu_wake_type wake_st;
   epiu_wake_type next_wake_st;

   // Watchdog oscillator sampled into the core clock
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wdt_a    <= 1'b0;
         wdt_b    <= 1'b0;
         wdt_prev <= 1'b0;
      end
      else
      begin
         wdt_a    <= wdt_osc_clk;
         wdt_b    <= wdt_a;
         wdt_prev <= wdt_b;
      end
   end

   assign wdt_tick = wdt_b & ~wdt_prev;
   assign lvl_wake = |(line_mask & lvl_mode & lows);

   // Two consecutive oscillator samples of the level
   always_comb
   begin
      next_wake_st = wake_st;
      case (wake_st)
         WAKE_IDLE:
            if (power_down && wdt_tick && lvl_wake)
               next_wake_st = WAKE_ONE;
         WAKE_ONE:
            if (!power_down)
               next_wake_st = WAKE_IDLE;
            else if (wdt_tick)
               next_wake_st = lvl_wake ? WAKE_UP
                                       : WAKE_IDLE;
         WAKE_UP:
            if (!sleep_active)
               next_wake_st = WAKE_IDLE;
         default:
            next_wake_st = WAKE_IDLE;
      endcase
   end

   // Wake held until the sleep controller leaves sleep
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wake_st  <= WAKE_IDLE;
         wake_req <= 1'b0;
      end
      else
      begin
         wake_st  <= next_wake_st;
         wake_req <= (next_wake_st == WAKE_UP);
      end
   end

   // ************************************************
   // Checks
   // ************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_GIE_GATE: assert property
      (!global_irq_enable |=> irq_req == 8'h00)
      else $error("request without global enable");
   AST_LEVEL_REQ: assert property
      (global_irq_enable && line_mask[0] && lvl_mode[0] &&
       lows[0] |=> irq_req[0])
      else $error("low level not requesting");
   AST_VECTOR: assert property
      (irq_pending |-> irq_req[irq_vector] &&
       ((irq_req & ((8'h01 << irq_vector) - 8'h01)) == 8'h00))
      else $error("vector not lowest pending line");
   AST_WAKE: assert property
      ($rose(wake_req) |-> $past(lvl_wake) && $past(power_down))
      else $error("wake without sampled level");
   AST_BUF_DIS: assert property
      (sleep_active && !line_mask[0] |=> input_buf_disable[0])
      else $error("buffer not disabled in sleep");
   AST_BHOLD: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped");
   AST_UNMAPPED: assert property
      (ar_hs && !rd_hit |=> rvalid && rresp == `EPIU_RESP_SLVERR)
      else $error("unmapped read not refused");

   COV_WRITE: cover property (do_write ##1 bvalid);
   COV_WAKE: cover property (power_down ##[1:400] wake_req);
   COV_VEC: cover property (irq_pending && irq_vector == 3'h5);
endmodule
`default_nettype wire

//--- test/epiu_cpu_model.sv
// CPU interrupt acceptance model answering pending requests
`timescale 1ns/1ps
`default_nettype none
module epiu_cpu_model
#(
   parameter int LAT = 2
)
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Acceptance control and requests
   input  wire logic        accept,
   input  wire logic        irq_pending,
   input  wire logic [2:0]  irq_vector,
   // Routine entry
   output logic             irq_ack,
   output logic [2:0]       irq_ack_line
);
   logic [3:0] wait_cnt;
   // Enters the routine of the vector after a short latency
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wait_cnt     <= 4'h0;
         irq_ack      <= 1'b0;
         irq_ack_line <= 3'h0;
      end
      else
      begin
         irq_ack <= 1'b0;
         if (accept && irq_pending && !irq_ack)
         begin
            if (wait_cnt == 4'(LAT))
            begin
               irq_ack      <= 1'b1;
               irq_ack_line <= irq_vector;
               wait_cnt     <= 4'h0;
            end
            else
               wait_cnt <= wait_cnt + 4'h1;
         end
         else
            wait_cnt <= 4'h0;
      end
   end
endmodule
`default_nettype wire

//--- test/external_pin_interrupt_unit_bench.sv
// Self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
`include "epiu_defines.svh"
module external_pin_interrupt_unit_bench;
   import epiu_pkg::*;
   typedef struct
   {
      int ln; epiu_sense_type sns; logic p0; logic p1; logic exp;
   } epiu_row_type;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [7:0]  pins;
   logic        wdt, gie, accept, sleep, pdown, io_run;
   logic        awready, wready, bvalid, arready, rvalid, irq_ack;
   logic        irq_pending, wake_req;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [2:0]  irq_ack_line, irq_vector;
   logic [7:0]  irq_req;
   logic [3:0]  buf_dis;
   int          mismatches, checks_done, cyc;
   epiu_row_type rows [8];
   // Design and far-side model
   epiu_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .ext_irq_pins(pins),
      .wdt_osc_clk(wdt), .global_irq_enable(gie), .irq_ack(irq_ack),
      .irq_ack_line(irq_ack_line), .io_clk_running(io_run),
      .sleep_active(sleep), .power_down(pdown), .irq_req(irq_req),
      .irq_pending(irq_pending), .irq_vector(irq_vector),
      .wake_req(wake_req), .input_buf_disable(buf_dis));
   epiu_cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .accept(accept),
      .irq_pending(irq_pending), .irq_vector(irq_vector),
      .irq_ack(irq_ack), .irq_ack_line(irq_ack_line));
   // Compares one value and counts it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   // AXI4-Lite write, address and data offered together
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (!ad && awready === 1'b1)
         begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!dd && wready === 1'b1)
         begin
            dd = 1'b1;
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1)
         begin
            chk(bresp, er, "write response");
            bready <= 1'b0;
            break;
         end
      end
   endtask
   // AXI4-Lite read with expected data and response
   task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      logic ad;
      ad = 1'b0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (!ad && arready === 1'b1)
         begin
            ad = 1'b1;
            arvalid <= 1'b0;
         end
         if (rvalid === 1'b1)
         begin
            chk(rdata, ed, "read data");
            chk(rresp, er, "read response");
            rready <= 1'b0;
            break;
         end
      end
   endtask
   // Prints the counts and the verdict, then ends the run
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Clock
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   // Hang guard
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         mismatches++;
         $display("wrong value at %0t: timeout", $time);
         summarize();
      end
   end
   // Main sequence
   initial
   begin
      int ln;
      logic [7:0] sd;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = '0;
      {wdt, accept, sleep, pdown} = 4'h0;
      io_run = 1'b1;
      pins = 8'hFF;
      gie = 1'b1;
      aresetn = 1'b0;
      rows = '{'{0, SENSE_FALL, 1'b1, 1'b0, 1'b1},
               '{1, SENSE_RISE, 1'b0, 1'b1, 1'b1},
               '{2, SENSE_ANY,  1'b1, 1'b0, 1'b0},
               '{3, SENSE_FALL, 1'b0, 1'b1, 1'b0},
               '{4, SENSE_ANY,  1'b1, 1'b0, 1'b1},
               '{5, SENSE_FALL, 1'b1, 1'b0, 1'b1},
               '{6, SENSE_RISE, 1'b0, 1'b1, 1'b1},
               '{7, SENSE_RISE, 1'b1, 1'b0, 1'b0}};
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      // Reset values and unmapped place
      rd(`EPIU_ADDR_FLAGS, 32'h0, `EPIU_RESP_OKAY);
      rd(`EPIU_ADDR_SENSE_HI, 32'h0, `EPIU_RESP_OKAY);
      rd(`EPIU_ADDR_SENSE_LO, 32'h0, `EPIU_RESP_OKAY);
      rd(`EPIU_ADDR_MASK, 32'h0, `EPIU_RESP_OKAY);
      rd(12'h004, 32'h0, `EPIU_RESP_SLVERR);
      wr(12'h004, 8'hFF, `EPIU_RESP_SLVERR);
      $display("test reset done");
      // Edge and change modes, one row per line
      for (int i = 0; i < 8; i++)
      begin
         ln = rows[i].ln;
         sd = 8'(rows[i].sns) << (2 * (ln % 4));
         wr(`EPIU_ADDR_MASK, 8'h00, `EPIU_RESP_OKAY);
         pins[ln] <= rows[i].p0;
         if (ln < 4)
            wr(`EPIU_ADDR_SENSE_LO, sd, `EPIU_RESP_OKAY);
         else
            wr(`EPIU_ADDR_SENSE_HI, sd, `EPIU_RESP_OKAY);
         wr(`EPIU_ADDR_FLAGS, 8'hFF, `EPIU_RESP_OKAY);
         wr(`EPIU_ADDR_MASK, 8'(1 << ln), `EPIU_RESP_OKAY);
         @(posedge aclk);
         pins[ln] <= rows[i].p1;
         repeat (8) @(posedge aclk);
         chk(irq_req[ln], rows[i].exp, "line request");
         chk(irq_vector, rows[i].exp ? ln : 0, "vector");
         rd(`EPIU_ADDR_FLAGS, 32'(rows[i].exp) << ln, 2'h0);
      end
      $display("test edge table done");
      // Priority, software clear and routine entry
      wr(`EPIU_ADDR_MASK, 8'h00, `EPIU_RESP_OKAY);
      pins <= 8'hFD;
      wr(`EPIU_ADDR_SENSE_LO, 8'h0C, `EPIU_RESP_OKAY);
      wr(`EPIU_ADDR_SENSE_HI, 8'h20, `EPIU_RESP_OKAY);
      wr(`EPIU_ADDR_FLAGS, 8'hFF, `EPIU_RESP_OKAY);
      wr(`EPIU_ADDR_MASK, 8'h42, `EPIU_RESP_OKAY);
      @(posedge aclk);
      pins <= 8'hBF;
      repeat (8) @(posedge aclk);
      chk(irq_vector, 3'h1, "lowest line first");
      chk(irq_pending, 1'b1, "pending");
      wr(`EPIU_ADDR_FLAGS, 8'h02, `EPIU_RESP_OKAY);
      rd(`EPIU_ADDR_FLAGS, 32'h40, `EPIU_RESP_OKAY);
      accept <= 1'b1;
      repeat (12) @(posedge aclk);
      chk(irq_pending, 1'b0, "cleared by routine entry");
      accept <= 1'b0;
      rd(`EPIU_ADDR_FLAGS, 32'h0, `EPIU_RESP_OKAY);
      $display("test priority done");
      // Stopped I/O clock hides edges on line 4
      wr(`EPIU_ADDR_MASK, 8'h00, `EPIU_RESP_OKAY);
      pins[4] <= 1'b0;
      wr(`EPIU_ADDR_SENSE_HI, 8'h03, `EPIU_RESP_OKAY);
      wr(`EPIU_ADDR_FLAGS, 8'hFF, `EPIU_RESP_OKAY);
      io_run <= 1'b0;
      pins[4] <= 1'b1;
      repeat (8) @(posedge aclk);
      rd(`EPIU_ADDR_FLAGS, 32'h0, `EPIU_RESP_OKAY);
      io_run <= 1'b1;
      $display("test stopped clock done");
      // Level mode, global enable and power-down wake
      wr(`EPIU_ADDR_MASK, 8'h00, `EPIU_RESP_OKAY);
      wr(`EPIU_ADDR_SENSE_LO, 8'h00, `EPIU_RESP_OKAY);
      wr(`EPIU_ADDR_SENSE_HI, 8'h00, `EPIU_RESP_OKAY);
      wr(`EPIU_ADDR_MASK, 8'h20, `EPIU_RESP_OKAY);
      pins <= 8'hDF;
      repeat (6) @(posedge aclk);
      chk(irq_req, 8'h20, "level request");
      chk(irq_vector, 3'h5, "level vector");
      rd(`EPIU_ADDR_FLAGS, 32'h0, `EPIU_RESP_OKAY);
      gie <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(irq_req, 8'h00, "global enable off");
      gie <= 1'b1;
      sleep <= 1'b1;
      pdown <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(buf_dis, 4'hF, "buffers off while masked");
      repeat (6)
      begin
         wdt <= ~wdt;
         repeat (4) @(posedge aclk);
      end
      chk(wake_req, 1'b1, "level wake");
      {sleep, pdown} <= 2'b00;
      pins <= 8'hFF;
      repeat (6) @(posedge aclk);
      chk(irq_req, 8'h00, "level released");
      $display("test level and wake done");
      summarize();
   end
endmodule
`default_nettype wire
